// File: shared/sbrc_map.vh
// Register map, field positions, reset values and timing counts of the reply configuration block
`ifndef SBRC_MAP_VH
`define SBRC_MAP_VH
`define SBRC_OFS_OPTION 8'h25
`define SBRC_OFS_ST0_LOW 8'h26
`define SBRC_OFS_ST0_HIGH 8'h27
`define SBRC_OFS_ST1_LOW 8'h28
`define SBRC_OFS_ST1_HIGH 8'h29
`define SBRC_OFS_CHECK 8'h2A
`define SBRC_OFS_STATUS 8'h2B
`define SBRC_BIT_PULLDOWN 7
`define SBRC_BIT_CHAIN 6
`define SBRC_BIT_LOWCUR 5
`define SBRC_BIT_WIDECLIP 4
`define SBRC_BIT_DETERR 3
`define SBRC_BIT_CRC 2
`define SBRC_BIT_P2EXT 1
`define SBRC_BIT_FREERUN 0
`define SBRC_FILTER_HI 7
`define SBRC_FILTER_LO 6
`define SBRC_RESET_BYTE 8'h00
`define SBRC_DEFAULT_START_US 13'h0014
`define SBRC_CLK_MHZ 125
`define SBRC_TICKS_PER_US 7'd125
`define SBRC_CLIP_NARROW_LO -102
`define SBRC_CLIP_NARROW_HI 307
`define SBRC_CLIP_WIDE 480
`define SBRC_ERROR_CODE 10'h1F4
`endif

// File: hw/sbrc_slot_timer.v
// Microsecond start-time counter for one reply source
`timescale 1ns/10ps
`include "sbrc_map.vh"
module sbrc_slot_timer (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire period_start,
   input wire enable,
   input wire [12:0] start_value,
   output reg start_pulse_ff
);
   // ==========================================
   // Effective start and counters
   localparam [6:0] TICK_LAST = `SBRC_TICKS_PER_US - 7'd1;
   reg [6:0] tick_ff;
   reg [12:0] us_ff;
   reg run_ff;
   wire [12:0] eff_start;
   assign eff_start = (start_value < `SBRC_DEFAULT_START_US) ? `SBRC_DEFAULT_START_US : start_value;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_ff <= 7'h00;
         us_ff <= 13'h0000;
         run_ff <= 1'b0;
         start_pulse_ff <= 1'b0;
      end else if (ce) begin
         start_pulse_ff <= 1'b0;
         if (period_start) begin
            tick_ff <= 7'h00;
            us_ff <= 13'h0000;
            run_ff <= enable;
         end else if (run_ff) begin
            if (tick_ff == TICK_LAST) begin
               tick_ff <= 7'h00;
               us_ff <= us_ff + 13'h0001;
               if (us_ff + 13'h0001 == eff_start) begin
                  start_pulse_ff <= 1'b1;
                  run_ff <= 1'b0;
               end
            end else begin
               tick_ff <= tick_ff + 7'h01;
            end
         end
      end
   end
endmodule // sbrc_slot_timer

// File: hw/sbrc_reply_config.v
// APB register bank and reply steering for the sensor bus reply configuration
`timescale 1ns/10ps
`include "sbrc_map.vh"
module sbrc_reply_config (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire psi5_mode,
   input wire diag_mode,
   input wire sync_detected,
   input wire period_start,
   input wire broadcast_read,
   input wire broadcast_kind,
   input wire init_phase2,
   input wire signed [10:0] rel_pressure,
   input wire internal_error,
   input wire [9:0] internal_error_code,
   output reg sync_pulldown_on_ff,
   output reg daisy_chain_on_ff,
   output reg low_current_on_ff,
   output reg crc_select_ff,
   output reg phase2_ext_on_ff,
   output reg free_running_send_send_ff,
   output reg [9:0] reply_data_ff,
   output reg reply_start_ff,
   output reg reply_source_ff,
   output reg reply_answer0_ff,
   output reg reply_answer1_ff,
   output reg check_error_ff
);
   // ==========================================
   // Pin synchronisers
   reg [1:0] s_psi5_ff;
   reg [1:0] s_diag_ff;
   reg [1:0] s_sync_ff;
   reg [1:0] s_per_ff;
   reg [1:0] s_brc_ff;
   reg [1:0] s_kind_ff;
   reg [1:0] s_p2_ff;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_psi5_ff <= 2'b00;
         s_diag_ff <= 2'b00;
         s_sync_ff <= 2'b00;
         s_per_ff <= 2'b00;
         s_brc_ff <= 2'b00;
         s_kind_ff <= 2'b00;
         s_p2_ff <= 2'b00;
      end else if (ce) begin
         s_psi5_ff <= {s_psi5_ff[0], psi5_mode};
         s_diag_ff <= {s_diag_ff[0], diag_mode};
         s_sync_ff <= {s_sync_ff[0], sync_detected};
         s_per_ff <= {s_per_ff[0], period_start};
         s_brc_ff <= {s_brc_ff[0], broadcast_read};
         s_kind_ff <= {s_kind_ff[0], broadcast_kind};
         s_p2_ff <= {s_p2_ff[0], init_phase2};
      end
   end
   wire psi5 = s_psi5_ff[1];
   wire diag = s_diag_ff[1];
   reg per_d_ff;
   reg brc_d_ff;
   wire per_pulse = s_per_ff[1] & ~per_d_ff;
   wire brc_pulse = s_brc_ff[1] & ~brc_d_ff;

   // ==========================================
   // Registers
   reg [7:0] option_ff;
   reg [7:0] st0_low_ff;
   reg [7:0] st0_high_ff;
   reg [7:0] st1_low_ff;
   reg [7:0] st1_high_ff;
   reg [7:0] check_ff;
   reg pd_armed_ff;
   // Register index is the word address, byte address is four times it
   wire [7:0] addr = paddr[9:2];
   wire acc_ok = ~psi5 | diag;
   wire is_st = (addr == `SBRC_OFS_ST0_LOW) | (addr == `SBRC_OFS_ST0_HIGH) |
                (addr == `SBRC_OFS_ST1_LOW) | (addr == `SBRC_OFS_ST1_HIGH);
   wire is_map = (addr == `SBRC_OFS_OPTION) | is_st | (addr == `SBRC_OFS_CHECK) | (addr == `SBRC_OFS_STATUS);
   wire hit_err = ~is_map | (paddr[31:10] != 22'h000000) | (paddr[1:0] != 2'b00) | (is_st & ~acc_ok);
   wire setup = psel & ~penable;
   wire wr = psel & penable & pready & pwrite & ~pslverr;
   wire [7:0] wb = pwdata[7:0];
   // Error detection XOR over the array
   wire [7:0] array_sum = option_ff ^ st0_low_ff ^ st0_high_ff ^ st1_low_ff ^ st1_high_ff;
   wire [7:0] status = {4'h0, check_error_ff, acc_ok, psi5, pd_armed_ff};
   reg [7:0] rd;
   always @* begin
      rd = 8'h00;
      case (addr)
         `SBRC_OFS_OPTION: rd = option_ff;
         `SBRC_OFS_ST0_LOW: rd = st0_low_ff;
         `SBRC_OFS_ST0_HIGH: rd = {st0_high_ff[7:6], 1'b0, st0_high_ff[4:0]};
         `SBRC_OFS_ST1_LOW: rd = st1_low_ff;
         `SBRC_OFS_ST1_HIGH: rd = {st1_high_ff[7:6], 1'b0, st1_high_ff[4:0]};
         `SBRC_OFS_CHECK: rd = check_ff;
         `SBRC_OFS_STATUS: rd = status;
         default: rd = 8'h00;
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         option_ff <= `SBRC_RESET_BYTE;
         st0_low_ff <= `SBRC_RESET_BYTE;
         st0_high_ff <= `SBRC_RESET_BYTE;
         st1_low_ff <= `SBRC_RESET_BYTE;
         st1_high_ff <= `SBRC_RESET_BYTE;
         check_ff <= `SBRC_RESET_BYTE;
      end else if (ce) begin
         pready <= setup;
         pslverr <= setup & hit_err;
         if (setup) begin
            prdata <= (hit_err | pwrite) ? 32'h00000000 : {24'h000000, rd};
         end
         if (wr) begin
            case (addr)
               `SBRC_OFS_OPTION: option_ff <= wb;
               `SBRC_OFS_ST0_LOW: st0_low_ff <= wb;
               `SBRC_OFS_ST0_HIGH: st0_high_ff <= {wb[7:6], 1'b0, wb[4:0]};
               `SBRC_OFS_ST1_LOW: st1_low_ff <= wb;
               `SBRC_OFS_ST1_HIGH: st1_high_ff <= {wb[7:6], 1'b0, wb[4:0]};
               `SBRC_OFS_CHECK: check_ff <= wb;
               default: check_ff <= check_ff;
            endcase
         end
      end
   end

   // ==========================================
   // Option decode
   wire chain = option_ff[`SBRC_BIT_CHAIN];
   wire free_eff = psi5 & option_ff[`SBRC_BIT_FREERUN] & ~chain;
   wire [12:0] st0 = {st0_high_ff[4:0], st0_low_ff};
   wire [12:0] st1 = {st1_high_ff[4:0], st1_low_ff};
   wire [1:0] flt0 = st0_high_ff[`SBRC_FILTER_HI:`SBRC_FILTER_LO];
   wire [1:0] flt1 = st1_high_ff[`SBRC_FILTER_HI:`SBRC_FILTER_LO];
   // Broadcast filter per source
   wire [1:0] flt [0:1];
   assign flt[0] = flt0;
   assign flt[1] = flt1;
   wire [1:0] ans;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_flt
         assign ans[g] = (flt[g] == 2'b00) | (flt[g] == 2'b11) |
                         ((flt[g] == 2'b01) & ~s_kind_ff[1]) | ((flt[g] == 2'b10) & s_kind_ff[1]);
      end
   endgenerate

   // ==========================================
   // Slot timers
   wire start0;
   wire start1;
   sbrc_slot_timer u_timer0 (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .period_start(per_pulse),
      .enable(~free_eff),
      .start_value(st0),
      .start_pulse_ff(start0)
   );
   sbrc_slot_timer u_timer1 (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .period_start(per_pulse),
      .enable(~free_eff),
      .start_value(st1),
      .start_pulse_ff(start1)
   );

   // ==========================================
   // Data shaping
   reg [9:0] nxt_data;
   always @* begin
      nxt_data = rel_pressure[9:0];
      if (option_ff[`SBRC_BIT_WIDECLIP]) begin
         if (rel_pressure > `SBRC_CLIP_WIDE)
            nxt_data = 10'h1E0;
         else if (rel_pressure < -`SBRC_CLIP_WIDE)
            nxt_data = 10'h220;
      end else begin
         if (rel_pressure > `SBRC_CLIP_NARROW_HI)
            nxt_data = 10'h133;
         else if (rel_pressure < `SBRC_CLIP_NARROW_LO)
            nxt_data = 10'h39A;
      end
      if (internal_error) begin
         nxt_data = option_ff[`SBRC_BIT_DETERR] ? internal_error_code : `SBRC_ERROR_CODE;
      end
   end

   // ==========================================
   // Outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_d_ff <= 1'b0;
         brc_d_ff <= 1'b0;
         pd_armed_ff <= 1'b0;
         sync_pulldown_on_ff <= 1'b0;
         daisy_chain_on_ff <= 1'b0;
         low_current_on_ff <= 1'b0;
         crc_select_ff <= 1'b0;
         phase2_ext_on_ff <= 1'b0;
         free_running_send_send_ff <= 1'b0;
         reply_data_ff <= 10'h000;
         reply_start_ff <= 1'b0;
         reply_source_ff <= 1'b0;
         reply_answer0_ff <= 1'b0;
         reply_answer1_ff <= 1'b0;
         check_error_ff <= 1'b0;
      end else if (ce) begin
         per_d_ff <= s_per_ff[1];
         brc_d_ff <= s_brc_ff[1];
         if (s_sync_ff[1] & psi5 & option_ff[`SBRC_BIT_PULLDOWN])
            pd_armed_ff <= 1'b1;
         else if (~psi5 | ~option_ff[`SBRC_BIT_PULLDOWN])
            pd_armed_ff <= 1'b0;
         sync_pulldown_on_ff <= pd_armed_ff;
         daisy_chain_on_ff <= psi5 & chain;
         low_current_on_ff <= psi5 & option_ff[`SBRC_BIT_LOWCUR];
         crc_select_ff <= psi5 & option_ff[`SBRC_BIT_CRC];
         phase2_ext_on_ff <= psi5 & s_p2_ff[1] & option_ff[`SBRC_BIT_P2EXT];
         free_running_send_send_ff <= free_eff;
         reply_data_ff <= nxt_data;
         reply_start_ff <= start0 | (start1 & ~free_eff);
         if (start1 & ~start0 & ~free_eff)
            reply_source_ff <= 1'b1;
         else if (start0)
            reply_source_ff <= 1'b0;
         if (brc_pulse) begin
            reply_answer0_ff <= ans[0];
            reply_answer1_ff <= ans[1] & ~(psi5 & (free_eff | chain));
         end
         check_error_ff <= (array_sum != check_ff);
      end
   end
endmodule // sbrc_reply_config

// File: tb/sbrc_reply_monitor.sv
// Port checker for the reply configuration block
`timescale 1ns/10ps
module sbrc_reply_monitor (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire psi5_mode,
   input wire signed [10:0] rel_pressure,
   input wire internal_error,
   input wire sync_pulldown_on_ff,
   input wire daisy_chain_on_ff,
   input wire free_running_send_send_ff,
   input wire [9:0] reply_data_ff,
   input wire reply_start_ff,
   input wire reply_source_ff
);
   // ====================
   // Assertions
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable && ce;
   endsequence
   sequence s_dsi3;
      (!psi5_mode && ce)[*6];
   endsequence
   a_ready_next: assert property (s_setup |=> pready) else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_refuse_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
      else $error("refused read not zero");
   a_dsi3_inert: assert property (s_dsi3 |-> !daisy_chain_on_ff && !free_running_send_send_ff)
      else $error("option active in dsi3");
   a_pulldown_off: assert property (s_dsi3 |-> !sync_pulldown_on_ff) else $error("pulldown in dsi3");
   a_free_running_send_chain: assert property (free_running_send_send_ff |-> !daisy_chain_on_ff) else $error("free_running_send with chain");
   a_data_pass: assert property (!internal_error && rel_pressure >= -102 && rel_pressure <= 307
      |=> reply_data_ff == $past(rel_pressure[9:0])) else $error("in range data changed");
   a_start_pulse: assert property (reply_start_ff |=> !reply_start_ff) else $error("start too long");
   a_free_running_send_tag0: assert property (reply_start_ff && free_running_send_send_ff |-> !reply_source_ff)
      else $error("source 1 in free_running_send");
endmodule // sbrc_reply_monitor
bind sbrc_reply_config sbrc_reply_monitor u_mon (.*);

// File: tb/sbrc_bus_master_model.sv
// Bus master model making sync pulses and broadcast reads
`timescale 1ns/10ps
module sbrc_bus_master_model (
   input wire pclk,
   input wire go_period,
   input wire go_brc,
   input wire brc_kind,
   output wire period_start,
   output wire sync_detected,
   output wire broadcast_read,
   output wire broadcast_kind
);
   // ====================
   // Pulse stretching
   reg [2:0] sync_cnt_ff = 3'h0;
   reg [2:0] brc_cnt_ff = 3'h0;
   reg kind_ff = 1'b0;
   always @(posedge pclk) begin
      if (go_period) begin
         sync_cnt_ff <= 3'h6;
      end else if (sync_cnt_ff != 3'h0) begin
         sync_cnt_ff <= sync_cnt_ff - 3'h1;
      end
      if (go_brc) begin
         brc_cnt_ff <= 3'h7;
         kind_ff <= brc_kind;
      end else if (brc_cnt_ff != 3'h0) begin
         brc_cnt_ff <= brc_cnt_ff - 3'h1;
      end
   end
   assign period_start = sync_cnt_ff != 3'h0;
   assign sync_detected = sync_cnt_ff != 3'h0;
   assign broadcast_read = brc_cnt_ff != 3'h0 && brc_cnt_ff < 3'h6;
   assign broadcast_kind = kind_ff;
endmodule // sbrc_bus_master_model

// File: tb/tb_top.sv
// Testbench of the reply configuration block
`timescale 1ns/10ps
`include "sbrc_map.vh"
module tb_top;
   // ====================
   // Signals
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic psi5_mode = 0, diag_mode = 0, init_phase2 = 0, internal_error = 0;
   logic go_period = 0, go_brc = 0, brc_kind = 0, e;
   logic [31:0] paddr = 0, pwdata = 0, rd;
   logic signed [10:0] rel_pressure = 0;
   logic [9:0] internal_error_code = 10'h155;
   wire [31:0] prdata;
   wire [9:0] reply_data_ff;
   wire pready, pslverr, period_start, sync_detected, broadcast_read, broadcast_kind;
   wire sync_pulldown_on_ff, daisy_chain_on_ff, low_current_on_ff, crc_select_ff;
   wire phase2_ext_on_ff, free_running_send_send_ff, reply_start_ff, reply_source_ff;
   wire reply_answer0_ff, reply_answer1_ff, check_error_ff;
   int err_total = 0, checks = 0, cyc = 0;
   sbrc_reply_config u_dut (.*);
   sbrc_bus_master_model u_mst (.*);
   initial begin
      forever #4 pclk = ~pclk;
   end
   // ====================
   // Tasks
   task automatic apb(input bit w, input [7:0] ix, input [7:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {22'h0, ix, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic chk(input [31:0] g, input [31:0] x);
      checks++;
      if (g !== x) begin
         err_total++;
         $display("wrong value t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic wr(input [7:0] ix, input [7:0] d);
      apb(1, ix, d);
   endtask
   task automatic rdc(input [7:0] ix, input [31:0] xe, input [31:0] x);
      apb(0, ix, 8'h00);
      chk({31'h0, e}, xe);
      chk(rd, x);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic t_regs;
      for (int i = `SBRC_OFS_OPTION; i <= `SBRC_OFS_ST1_HIGH; i++) begin
         rdc(i[7:0], 0, 0);
         wr(i[7:0], 8'hFF);
         rdc(i[7:0], 0, (i == 'h27 || i == 'h29) ? 32'hDF : 32'hFF);
      end
      wt(6);
      chk({daisy_chain_on_ff, free_running_send_send_ff, low_current_on_ff, crc_select_ff, phase2_ext_on_ff}, 0);
      chk({31'h0, check_error_ff}, 1);
      wr(`SBRC_OFS_CHECK, 8'hFF);
      wt(3);
      chk({31'h0, check_error_ff}, 0);
      $display("test regs done");
   endtask
   task automatic t_filter;
      for (int f = 0; f < 4; f++) for (int k = 0; k < 2; k++) begin
         wr(`SBRC_OFS_ST0_HIGH, {f[1:0], 6'h0});
         wr(`SBRC_OFS_ST1_HIGH, {f[1:0], 6'h0});
         @(posedge pclk);
         brc_kind <= k[0];
         go_brc <= 1;
         @(posedge pclk);
         go_brc <= 0;
         wt(10);
         chk({reply_answer0_ff, reply_answer1_ff}, (f == 0 || f == 3 || f == k + 1) ? 2'h3 : 2'h0);
      end
      $display("test filter done");
   endtask
   task automatic t_start(input [12:0] v, input int u);
      int n;
      logic [12:0] w;
      w = v + 13'd30;
      wr(`SBRC_OFS_ST0_LOW, v[7:0]);
      wr(`SBRC_OFS_ST0_HIGH, {3'h0, v[12:8]});
      wr(`SBRC_OFS_ST1_LOW, w[7:0]);
      wr(`SBRC_OFS_ST1_HIGH, {3'h0, w[12:8]});
      @(posedge pclk);
      go_period <= 1;
      @(posedge pclk);
      go_period <= 0;
      n = 0;
      for (int s = 0; s < 2; s++) begin
         int t;
         t = (s == 1) ? int'(w) * 125 : u * 125;
         do begin
            @(posedge pclk);
            n++;
         end while (reply_start_ff !== 1'b1 && n < 20000);
         chk({31'h0, reply_source_ff}, s);
         chk({31'h0, n >= t && n <= t + 12}, 1);
      end
      $display("test start time done");
   endtask
   task automatic t_access;
      @(posedge pclk);
      psi5_mode <= 1;
      wt(6);
      rdc(`SBRC_OFS_ST0_LOW, 1, 0);
      rdc(8'h30, 1, 0);
      @(posedge pclk);
      diag_mode <= 1;
      wt(6);
      rdc(`SBRC_OFS_ST0_LOW, 0, 25);
      $display("test access done");
   endtask
   task automatic t_psi5;
      @(posedge pclk);
      init_phase2 <= 1;
      go_period <= 1;
      @(posedge pclk);
      go_period <= 0;
      wt(10);
      chk({sync_pulldown_on_ff, daisy_chain_on_ff, low_current_on_ff, crc_select_ff, phase2_ext_on_ff,
         free_running_send_send_ff}, 6'h3E);
      wr(`SBRC_OFS_OPTION, 8'h01);
      wt(6);
      chk({daisy_chain_on_ff, free_running_send_send_ff}, 2'h1);
      $display("test psi5 options done");
   endtask
   task automatic t_clip(input [7:0] opt, input signed [10:0] p, input bit ie, input [9:0] x);
      wr(`SBRC_OFS_OPTION, opt);
      @(posedge pclk);
      rel_pressure <= p;
      internal_error <= ie;
      wt(2);
      chk(reply_data_ff, x);
      $display("test clip done");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ====================
   // Sequence and timeout
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         finish_test;
      end
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      t_regs;
      t_filter;
      t_start(13'd0, 20);
      t_start(13'd19, 20);
      t_start(13'd25, 25);
      t_access;
      t_psi5;
      t_clip(8'h00, 400, 0, 10'd307);
      t_clip(8'h00, -200, 0, 10'h39A);
      t_clip(8'h10, 600, 0, 10'd480);
      t_clip(8'h10, -600, 0, 10'h220);
      t_clip(8'h00, 100, 1, `SBRC_ERROR_CODE);
      finish_test;
   end
endmodule // tb_top
